/* hdl/scdp_top.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: sample clock divider control with phase offset and sysref autophase
// Assumes: i_clk is the input sample clock, 50 MHz; apb slave, zero wait state
// Notes:   half-cycle offsets are carried as an invert flag for the clock tree
//
// Overview of operation
// - The four-bit phase code delays the divided clock by code half input cycles, 0001 meaning invert.
// - With autophase set a sysref edge outside the window realigns the divider, with it clear sysref only updates the in-window status bit.
// - The autophase bit reads 0 after reset so realignment is off until software sets it.
// - Negative window codes 00 to 11 tolerate early capture of 0, 0.5, 1 and 1.5 device clocks.
// - The positive window sits in bits 1 to 0 of the align register and resets to 00.
// - Positive window codes 01, 10, 11 tolerate late capture of 0.5, 1 and 1.5 device clocks.
//////////////////////////////////////////////////////////////////////////////
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module scdp_top
  import scdp_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // sysref pin
  input  wire logic        i_sysref,
  // divided clock
  output logic             o_div_clk,
  output logic             o_div_tick,
  output logic             o_div_invert,
  output logic             o_realign
);

  scdp_div_if dv ();

  logic [3:0]            phase_code;
  logic                  autophase;
  logic [1:0]            neg_win;
  logic [1:0]            pos_win;
  logic [2:0]            ratio_code;
  logic [2:0]            ratio_m;
  logic                  ratio_bad;
  logic [7:0]            realign_cnt;
  logic                  sync_a;
  logic                  sync_b;
  logic                  sync_c;
  logic                  setup;
  logic                  wr_take;
  logic [31:0]           next_rdata;
  logic                  next_err;
  logic                  lvl_now;
  logic [DELAY_TAPS-1:0] lvl_line;
  logic [DELAY_TAPS-1:0] tick_line;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign setup   = i_psel && !i_penable;
  assign wr_take = i_psel && i_penable && o_pready && i_pwrite;

  // read mux, reserved bits read zero
  always_comb begin
    next_rdata = 32'h0;
    next_err   = 1'b0;
    case (i_paddr)
      PHASE_ADDR:  next_rdata[3:0] = phase_code;
      ALIGN_ADDR:  next_rdata[7:0] = {autophase, 3'h0, neg_win, pos_win};
      RATIO_ADDR:  next_rdata[2:0] = ratio_code;
      STATUS_ADDR: next_rdata[15:0] = {realign_cnt, 5'h0, dv.in_window, autophase, ratio_bad};
      default:     next_err = 1'b1;
    endcase
  end

  // answer one cycle after setup
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && next_err;
      if (setup)
        o_prdata <= i_pwrite ? 32'h0 : next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge i_clk) begin
    if (i_rst)
      phase_code <= PHASE_RST;
    else if (wr_take && i_paddr == PHASE_ADDR)
      phase_code <= i_pwdata[PHASE_LSB +: 4];
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      autophase <= AUTO_RST;
      neg_win   <= WIN_RST;
      pos_win   <= WIN_RST;
    end else if (wr_take && i_paddr == ALIGN_ADDR) begin
      autophase <= i_pwdata[AUTO_BIT];
      neg_win   <= i_pwdata[NEG_LSB +: 2];
      pos_win   <= i_pwdata[POS_LSB +: 2];
    end
  end

  // stored ratio code, any value may be written
  always_ff @(posedge i_clk) begin
    if (i_rst)
      ratio_code <= RATIO_RST;
    else if (wr_take && i_paddr == RATIO_ADDR)
      ratio_code <= i_pwdata[2:0];
  end

  // only supported codes reach the divider
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ratio_m   <= RATIO_RST;
      ratio_bad <= 1'b0;
    end else begin
      case (ratio_code)
        RATIO_DIV1, RATIO_DIV2, RATIO_DIV4, RATIO_DIV8: begin
          ratio_m   <= ratio_code;
          ratio_bad <= 1'b0;
        end
        default: begin
          ratio_bad <= 1'b1;  // divider keeps the last good ratio
        end
      endcase
    end
  end

  // realignment counter, saturating
  always_ff @(posedge i_clk) begin
    if (i_rst)
      realign_cnt <= 8'h0;
    else if (dv.realign && realign_cnt != 8'hff)
      realign_cnt <= 8'(realign_cnt + 8'h1);
  end

  //////////////////////////////////////////////////////////////////////////////
  // sysref synchroniser and edge detect

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= i_sysref;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // exact capture assumed when window is 00
  assign dv.sysref_edge = sync_b && !sync_c;
  assign dv.ratio_m     = ratio_m;
  assign dv.autophase   = autophase;
  assign dv.neg_win     = neg_win;
  assign dv.pos_win     = pos_win;

  scdp_divider u_div (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .dv    (dv.div)
  );

  //////////////////////////////////////////////////////////////////////////////
  // whole-cycle phase delay line

  // high for the first half of the period, steady high when dividing by 1
  assign lvl_now = (ratio_m == RATIO_DIV1) ? 1'b1 : ({1'b0, dv.cnt} < {1'b0, 3'((ratio_m >> 1) + 3'h1)});

  generate
    for (genvar k = 0; k < DELAY_TAPS; k++) begin : g_tap
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          lvl_line[k]  <= 1'b0;
          tick_line[k] <= 1'b0;
        end else if (k == 0) begin
          lvl_line[k]  <= lvl_now;
          tick_line[k] <= (dv.cnt == 3'h0);
        end else begin
          lvl_line[k]  <= lvl_line[(k == 0) ? 0 : k - 1];
          tick_line[k] <= tick_line[(k == 0) ? 0 : k - 1];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_div_clk    <= 1'b0;
      o_div_tick   <= 1'b0;
      o_div_invert <= 1'b0;
      o_realign    <= 1'b0;
    end else begin
      o_div_clk    <= lvl_line[phase_code[3:1]];
      o_div_tick   <= tick_line[phase_code[3:1]];
      o_div_invert <= phase_code[0];
      o_realign    <= dv.realign;
    end
  end

endmodule : scdp_top

/* hdl/scdp_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants shared by the sample clock divider and phase block
// Assumes: 32-bit apb data, register byte address = index * 4
// Notes:   ratio codes are the terminal count of the divider, the divide ratio minus one
//////////////////////////////////////////////////////////////////////////////
package scdp_pkg;

  // register indices and byte addresses
  localparam logic [9:0]  PHASE_IDX     = 10'h109;
  localparam logic [9:0]  ALIGN_IDX     = 10'h10a;
  localparam logic [9:0]  RATIO_IDX     = 10'h120;
  localparam logic [9:0]  STATUS_IDX    = 10'h121;
  localparam logic [11:0] PHASE_ADDR    = {PHASE_IDX, 2'b00};
  localparam logic [11:0] ALIGN_ADDR    = {ALIGN_IDX, 2'b00};
  localparam logic [11:0] RATIO_ADDR    = {RATIO_IDX, 2'b00};
  localparam logic [11:0] STATUS_ADDR   = {STATUS_IDX, 2'b00};

  // field positions
  localparam int          AUTO_BIT      = 7;
  localparam int          NEG_LSB       = 2;
  localparam int          POS_LSB       = 0;
  localparam int          PHASE_LSB     = 0;

  // values after reset
  localparam logic [3:0]  PHASE_RST     = 4'h0;
  localparam logic [1:0]  WIN_RST       = 2'h0;
  localparam logic        AUTO_RST      = 1'b0;
  localparam logic [2:0]  RATIO_RST     = 3'h1;

  // supported divider ratio codes
  localparam logic [2:0]  RATIO_DIV1    = 3'h0;
  localparam logic [2:0]  RATIO_DIV2    = 3'h1;
  localparam logic [2:0]  RATIO_DIV4    = 3'h3;
  localparam logic [2:0]  RATIO_DIV8    = 3'h7;

  // depth of the whole-cycle phase delay line
  localparam int          DELAY_TAPS    = 8;

endpackage : scdp_pkg

/* hdl/scdp_div_if.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: settings and events between the control top and the divider
// Assumes: single clock domain
// Notes:   none
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
interface scdp_div_if;
  logic [2:0] ratio_m;      // terminal count, n - 1
  logic       autophase;
  logic [1:0] neg_win;
  logic [1:0] pos_win;
  logic       sysref_edge;  // one-cycle, from synchronised pin
  logic [2:0] cnt;
  logic       realign;      // one-cycle, counter was moved
  logic       in_window;    // last edge fell inside the window

  modport ctrl (output ratio_m, autophase, neg_win, pos_win, sysref_edge,
                input  cnt, realign, in_window);
  modport div  (input  ratio_m, autophase, neg_win, pos_win, sysref_edge,
                output cnt, realign, in_window);
endinterface : scdp_div_if

/* hdl/scdp_divider.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose: divider counter with sysref-driven phase realignment
// Assumes: ratio_m is one of 0, 1, 3, 7
// Notes:   count 0 is the divider phase reference
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module scdp_divider
  import scdp_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // settings and events
  scdp_div_if.div   dv
);

  logic [2:0] late_cyc;
  logic [2:0] early_cyc;
  logic       tolerate;

  // distance of the sysref edge from the reference count, in cycles
  assign late_cyc  = dv.cnt;
  assign early_cyc = 3'(dv.ratio_m - dv.cnt + 3'h1);

  always_comb begin
    tolerate = (dv.cnt == 3'h0);
    if ({1'b0, late_cyc, 1'b0} <= {3'h0, dv.pos_win})
      tolerate = 1'b1;
    if ({1'b0, early_cyc, 1'b0} <= {3'h0, dv.neg_win})
      tolerate = 1'b1;
  end

  // divider counter
  // realign on sysref
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dv.cnt <= 3'h0;
    end else if (dv.sysref_edge && dv.autophase && !tolerate) begin
      dv.cnt <= 3'h1 & dv.ratio_m;  // edge cycle becomes count 0
    end else if (dv.cnt >= dv.ratio_m) begin
      dv.cnt <= 3'h0;
    end else begin
      dv.cnt <= 3'(dv.cnt + 3'h1);
    end
  end

  // realign pulse and window result
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dv.realign   <= 1'b0;
      dv.in_window <= 1'b1;
    end else begin
      dv.realign <= dv.sysref_edge && dv.autophase && !tolerate;
      if (dv.sysref_edge)
        dv.in_window <= tolerate;
    end
  end

endmodule : scdp_divider

/* sim/scdp_chk.sv */
// Purpose: port-level assertions for the divider control block
// Assumes: one clock, synchronous active-high reset
// Notes:   phase and autophase are shadowed from apb writes
`timescale 1ns/100ps
module scdp_chk
  import scdp_pkg::*;
(
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // apb
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  // divider outputs
  input wire logic        o_div_tick,
  input wire logic        o_div_invert,
  input wire logic        o_realign
);
  logic [3:0] ph_q;
  logic       auto_q;
  wire        wr_done = i_psel && i_penable && o_pready && i_pwrite;
  // shadow of the written settings
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ph_q   <= PHASE_RST;
      auto_q <= AUTO_RST;
    end else if (wr_done && i_paddr == PHASE_ADDR) begin
      ph_q <= i_pwdata[3:0];
    end else if (wr_done && i_paddr == ALIGN_ADDR) begin
      auto_q <= i_pwdata[AUTO_BIT];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_RDY_NEXT:
    assert property (i_psel && !i_penable |=> o_pready) else $error("no ready after setup");
  AST_RDY_ONE:
    assert property (o_pready |=> !o_pready) else $error("ready held too long");
  AST_ERR_RDY:
    assert property (o_pslverr |-> o_pready) else $error("error without ready");
  AST_WR_ZERO:
    assert property (o_pready && i_pwrite |-> o_prdata == 32'h0) else $error("write returned data");
  AST_INVERT:
    assert property ($stable(ph_q) [*3] |-> o_div_invert == ph_q[0]) else $error("invert wrong");
  AST_NO_AUTO:
    assert property (!auto_q [*6] |-> !o_realign) else $error("realign while disabled");
  // the edge cycle becomes count 0, so with no whole-cycle offset a tick lands
  // eight cycles after the realign pulse for every supported ratio
  AST_RA_TICK:
    assert property (o_realign && ph_q[3:1] == 3'h0 |-> ##8 o_div_tick) else $error("tick not aligned to realign");
  AST_RA_ONE:
    assert property (o_realign |=> !o_realign) else $error("realign pulse too long");
endmodule : scdp_chk
bind scdp_top scdp_chk scdp_chk_inst (.*);

/* sim/scdp_sysref_src.sv */
// Purpose: sysref source beside the divider control block
// Assumes: pin idles low between events
// Notes:   hold length sets a prompt or slow source
`timescale 1ns/100ps
module scdp_sysref_src (
  // clock
  input  wire logic i_clk,
  // sysref pin
  output logic      o_sysref
);
  initial o_sysref = 1'b0;
  // clean edge, held then released low
  task automatic pulse(input int hold);
    @(posedge i_clk);
    o_sysref <= 1'b1;
    repeat (hold) @(posedge i_clk);
    o_sysref <= 1'b0;
  endtask : pulse
endmodule : scdp_sysref_src

/* sim/testbench.sv */
// Purpose: self-checking bench for the divider control block
// Assumes: apb slave, 50 MHz clock
// Notes:   realign windows swept over all eight count offsets
`timescale 1ns/100ps
module testbench;
  import scdp_pkg::*;
  logic        i_clk, i_rst, i_psel, i_penable, i_pwrite, i_sysref, err;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, o_div_clk, o_div_tick, o_div_invert, o_realign;
  int          num_errors, n_tests, cyc, t0, i, n, h;
  logic [2:0]  rc [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2};
  int          ex [5] = '{64, 32, 16, 8, 8};
  scdp_top        scdp_top_inst (.*);
  scdp_sysref_src scdp_sysref_src_inst (.i_clk(i_clk), .o_sysref(i_sysref));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cyc <= cyc + 1;
  task automatic give_verdict();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic hang(input int k);
    if (k >= 40) begin
      num_errors++;
      give_verdict();
    end
  endtask : hang
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 40);
    hang(k);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask : rchk
  task automatic wait_tick();
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_div_tick !== 1'b1 && k < 40);
    hang(k);
  endtask : wait_tick
  // tick moves by whole cycles, half step shows as invert
  task automatic phs(input logic [3:0] code);
    apb(1'b1, PHASE_ADDR, 32'h0);
    repeat (12) @(posedge i_clk);
    wait_tick();
    t0 = cyc;
    apb(1'b1, PHASE_ADDR, {28'h0, code});
    repeat (12) @(posedge i_clk);
    wait_tick();
    chk((cyc - t0) % 8, code[3:1], "tick shift");
    chk(o_div_invert, code[0], "invert");
  endtask : phs
  // one sysref edge at each of the eight counts, realigns counted
  task automatic sweep(input logic [7:0] ctl, input int exp);
    int k, m;
    m = 0;
    apb(1'b1, ALIGN_ADDR, {24'h0, ctl});
    for (k = 0; k < 8; k++) begin
      wait_tick();
      repeat (k) @(posedge i_clk);
      scdp_sysref_src_inst.pulse(2 + k % 2);
      repeat (12) begin
        @(posedge i_clk);
        if (o_realign === 1'b1) m++;
      end
    end
    chk(m, exp, "realign count");
  endtask : sweep
  initial begin
    {i_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {4'h8, 44'h0};
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    rchk(PHASE_ADDR, 32'h0, "phase reset");
    rchk(ALIGN_ADDR, 32'h0, "align reset");
    rchk(RATIO_ADDR, 32'h1, "ratio reset");
    rchk(12'h000, 32'h0, "unmapped read");
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b1, ALIGN_ADDR, 32'hff);
    rchk(ALIGN_ADDR, 32'h8f, "align fields");
    apb(1'b1, PHASE_ADDR, 32'hff);
    rchk(PHASE_ADDR, 32'h0f, "phase field");
    apb(1'b1, ALIGN_ADDR, 32'h0);
    // settle past the ratio change and the longest tap before counting
    for (i = 0; i < 5; i++) begin
      apb(1'b1, RATIO_ADDR, {29'h0, rc[i]});
      repeat (16) @(posedge i_clk);
      n = 0;
      h = 0;
      repeat (64) begin
        @(posedge i_clk);
        if (o_div_tick === 1'b1) n++;
        if (o_div_clk === 1'b1) h++;
      end
      chk(n, ex[i], "ticks per 64");
      chk(h, (i == 0) ? 64 : 32, "clock high per 64");
    end
    rchk(RATIO_ADDR, 32'h2, "ratio stored");
    rchk(STATUS_ADDR, 32'h5, "status unsupported ratio");
    phs(4'h1);
    phs(4'hf);
    phs(4'h6);
    apb(1'b1, PHASE_ADDR, 32'h0);
    sweep(8'h00, 0);
    sweep(8'h80, 7);
    sweep(8'h85, 7);
    sweep(8'h8a, 5);
    sweep(8'h8f, 5);
    sweep(8'h82, 6);
    sweep(8'h88, 6);
    rchk(STATUS_ADDR, 32'h2403, "status after sweep");
    // mid-run reset with autophase set must clear it again
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    rchk(ALIGN_ADDR, 32'h0, "align after reset");
    rchk(STATUS_ADDR, 32'h4, "status after reset");
    give_verdict();
  end
endmodule : testbench
